// ### rtl/ccc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - clock and calendar run only while module enable is set
// - module enable write accepted only while value write unlock is set
// - time window writes take effect only while unlock is set
// - ripple sync status high while value reads may tear
// - half second status low in first half, high in second half
// - writing seconds clears half second status
// - clock pin driven only while pin output enable set
// - time window pointer selects minute/weekday/month and second/hour/day/year
// - time pointer decrements on each high window access, stops at zero
// - configuration register reset only by power-on reset; clock keeps running
// - calibration adds or removes four pulses per minute per unit
// - pin source: alarm pulse, seconds clock, raw source; 11 reserved
// - alarm events only while enabled; auto-clear when count zero, no chime
// - four bit mask selects interval half second to yearly; rest reserved
// - yearly alarm on february 29 fires only in leap years
// - alarm pointer selects alarm minute/weekday/month and second/hour/day
// - alarm pointer decrements on each high window access, stops at zero
// - repeat counter holds further repeats, decrements on each alarm event
// - repeat counter wraps 00 to FF only with chime enabled
// - time and alarm values except weekday held as packed bcd digit pairs
module ccc_top
(
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  input  wire logic       por_in,
  input  wire logic       src_clk_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            clk_pin_out,
  output logic            clk_pin_oe_out,
  output logic            alarm_event_out
);
  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic       en;
    logic       unlock;
    logic       oe;
    logic [1:0] tptr;
    logic [7:0] cal;
    logic [1:0] sel;
    logic       alm_en;
    logic       chime;
    logic [3:0] mask;
    logic [1:0] aptr;
    logic [7:0] rpt;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] year;
    logic [2:0] wday;
    logic [7:0] a_sec;
    logic [7:0] a_min;
    logic [7:0] a_hour;
    logic [7:0] a_day;
    logic [7:0] a_mon;
    logic [2:0] a_wday;
    logic [14:0] pre;
    logic [9:0] adj;
    logic [2:0] src_s;
    logic       sec_evt;
    logic       half_evt;
    logic       alm_evt;
    logic       alm_pulse;
    logic       pin;
    logic       pin_oe;
    logic [7:0] rd;
  } ccc_state_type;

  ccc_state_type q;
  ccc_state_type d;

  logic       match;
  logic       leap;
  logic       sync_st;
  logic       evt;
  logic       src_tick;
  logic [7:0] rmux;

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                         input logic [7:0] first);
    if (v == last)
      return {1'b1, first};
    else if (v[3:0] == 4'h9)
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] days_in(input logic [7:0] m, input logic lp);
    if (m == ccc_pkg::BCD_02)
      return lp ? ccc_pkg::BCD_29 : ccc_pkg::BCD_28;
    else if (m == ccc_pkg::BCD_04 || m == ccc_pkg::BCD_06 || m == ccc_pkg::BCD_09
             || m == ccc_pkg::BCD_11)
      return ccc_pkg::BCD_30;
    else
      return ccc_pkg::BCD_31;
  endfunction : days_in

  // bcd year divisible by four: even tens with 0/4/8, odd tens with 2/6
  assign leap = q.year[4] ? (q.year[3:0] == 4'h2 || q.year[3:0] == 4'h6)
                          : (q.year[3:0] == 4'h0 || q.year[3:0] == 4'h4
                             || q.year[3:0] == 4'h8);
  // last few pulses of a second may ripple through all fields
  assign sync_st  = q.en && (q.pre >= ccc_pkg::SYNC_START);
  assign src_tick = q.src_s[1] && !q.src_s[2];

  ccc_alarm_match u_match
  (
    .sec_in    (q.sec),
    .min_in    (q.min),
    .hour_in   (q.hour),
    .day_in    (q.day),
    .mon_in    (q.mon),
    .wday_in   (q.wday),
    .a_sec_in  (q.a_sec),
    .a_min_in  (q.a_min),
    .a_hour_in (q.a_hour),
    .a_day_in  (q.a_day),
    .a_mon_in  (q.a_mon),
    .a_wday_in (q.a_wday),
    .mask_in   (q.mask),
    .leap_in   (leap),
    .match_out (match)
  );

  // time fields update on the second event, so matching looks one cycle later
  assign evt = q.alm_en && match
               && (q.sec_evt || (q.half_evt && q.mask == ccc_pkg::MASK_HALF));

  // ==========================================================================
  // read mux
  // ==========================================================================
  always_comb
  begin
    rmux = 8'h00;
    unique case (addr_in)
      ccc_pkg::REG_CFG:
      begin
        rmux[ccc_pkg::CFG_EN_BIT]     = q.en;
        rmux[ccc_pkg::CFG_UNLOCK_BIT] = q.unlock;
        rmux[ccc_pkg::CFG_SYNC_BIT]   = sync_st;
        rmux[ccc_pkg::CFG_HALF_BIT]   = q.pre[ccc_pkg::PRE_W-1];
        rmux[ccc_pkg::CFG_OE_BIT]     = q.oe;
        rmux[1:0]                     = q.tptr;
      end
      ccc_pkg::REG_CAL:  rmux = q.cal;
      ccc_pkg::REG_PAD:  rmux[ccc_pkg::PAD_SEL_LSB +: 2] = q.sel;
      ccc_pkg::REG_ACFG: rmux = {q.alm_en, q.chime, q.mask, q.aptr};
      ccc_pkg::REG_ALARM_REPEAT_VALUE: rmux = q.rpt;
      ccc_pkg::REG_TWH:
        unique case (q.tptr)
          ccc_pkg::PTR_0: rmux = q.min;
          ccc_pkg::PTR_1: rmux = {5'h00, q.wday};
          ccc_pkg::PTR_2: rmux = q.mon;
          ccc_pkg::PTR_3: rmux = 8'h00;
        endcase
      ccc_pkg::REG_TWL:
        unique case (q.tptr)
          ccc_pkg::PTR_0: rmux = q.sec;
          ccc_pkg::PTR_1: rmux = q.hour;
          ccc_pkg::PTR_2: rmux = q.day;
          ccc_pkg::PTR_3: rmux = q.year;
        endcase
      ccc_pkg::REG_AWH:
        unique case (q.aptr)
          ccc_pkg::PTR_0: rmux = q.a_min;
          ccc_pkg::PTR_1: rmux = {5'h00, q.a_wday};
          ccc_pkg::PTR_2: rmux = q.a_mon;
          ccc_pkg::PTR_3: rmux = 8'h00;
        endcase
      ccc_pkg::REG_AWL:
        unique case (q.aptr)
          ccc_pkg::PTR_0: rmux = q.a_sec;
          ccc_pkg::PTR_1: rmux = q.a_hour;
          ccc_pkg::PTR_2: rmux = q.a_day;
          ccc_pkg::PTR_3: rmux = 8'h00;
        endcase
      default: rmux = 8'h00;
    endcase
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    logic [15:0] psum;
    logic [1:0]  step;
    logic [8:0]  r;
    psum = 16'h0000;
    step = 2'h1;
    r    = 9'h000;
    d    = q;
    d.src_s    = {q.src_s[1:0], src_clk_in};
    d.sec_evt  = 1'b0;
    d.half_evt = 1'b0;
    d.alm_evt  = evt;
    d.rd       = rd_in ? rmux : 8'h00;

    // time base with calibration spread over the pulses after each minute
    if (q.en && src_tick)
    begin
      if (q.adj != 10'h000 && !q.adj[9])
      begin
        step  = 2'h2;
        d.adj = q.adj - 10'h001;
      end
      else if (q.adj[9])
      begin
        step  = 2'h0;
        d.adj = q.adj + 10'h001;
      end
      psum       = {1'b0, q.pre} + {14'h0000, step};
      d.pre      = psum[14:0];
      d.half_evt = psum[14] && !q.pre[14];
      d.sec_evt  = psum[15];
      if (psum[15])
      begin
        r     = bcd_inc(q.sec, ccc_pkg::BCD_59, ccc_pkg::BCD_00);
        d.sec = r[7:0];
        if (r[8])
        begin
          d.adj = {q.cal, 2'h0};
          r     = bcd_inc(q.min, ccc_pkg::BCD_59, ccc_pkg::BCD_00);
          d.min = r[7:0];
          if (r[8])
          begin
            r      = bcd_inc(q.hour, ccc_pkg::BCD_23, ccc_pkg::BCD_00);
            d.hour = r[7:0];
            if (r[8])
            begin
              d.wday = (q.wday == ccc_pkg::WDAY_LAST) ? 3'h0 : q.wday + 3'h1;
              r      = bcd_inc(q.day, days_in(q.mon, leap), ccc_pkg::BCD_01);
              d.day  = r[7:0];
              if (r[8])
              begin
                r     = bcd_inc(q.mon, ccc_pkg::BCD_12, ccc_pkg::BCD_01);
                d.mon = r[7:0];
                if (r[8])
                begin
                  r      = bcd_inc(q.year, ccc_pkg::BCD_99, ccc_pkg::BCD_00);
                  d.year = r[7:0];
                end
              end
            end
          end
        end
      end
    end

    // alarm event bookkeeping
    if (evt)
    begin
      d.alm_pulse = !q.alm_pulse;
      if (q.rpt != 8'h00)
        d.rpt = q.rpt - 8'h01;
      else if (q.chime)
        d.rpt = ccc_pkg::RPT_MAX;
      else
        d.alm_en = 1'b0;
    end

    // software accesses win over same-cycle hardware updates
    if (wr_in)
    begin
      unique case (addr_in)
        ccc_pkg::REG_CFG:
        begin
          if (q.unlock)
            d.en = wdata_in[ccc_pkg::CFG_EN_BIT];
          d.unlock = wdata_in[ccc_pkg::CFG_UNLOCK_BIT];
          d.oe     = wdata_in[ccc_pkg::CFG_OE_BIT];
          d.tptr   = wdata_in[1:0];
        end
        ccc_pkg::REG_CAL:  d.cal = wdata_in;
        ccc_pkg::REG_PAD:  d.sel = wdata_in[ccc_pkg::PAD_SEL_LSB +: 2];
        ccc_pkg::REG_ACFG:
        begin
          d.alm_en = wdata_in[ccc_pkg::ACFG_EN_BIT];
          d.chime  = wdata_in[ccc_pkg::ACFG_CHIME_BIT];
          d.mask   = wdata_in[ccc_pkg::ACFG_MASK_LSB +: 4];
          d.aptr   = wdata_in[1:0];
        end
        ccc_pkg::REG_ALARM_REPEAT_VALUE: d.rpt = wdata_in;
        ccc_pkg::REG_TWH:
          if (q.unlock)
            unique case (q.tptr)
              ccc_pkg::PTR_0: d.min  = wdata_in;
              ccc_pkg::PTR_1: d.wday = wdata_in[2:0];
              ccc_pkg::PTR_2: d.mon  = wdata_in;
              ccc_pkg::PTR_3: d.mon  = d.mon;
            endcase
        ccc_pkg::REG_TWL:
          if (q.unlock)
            unique case (q.tptr)
              ccc_pkg::PTR_0:
              begin
                d.sec = wdata_in;
                d.pre = 15'h0000;
              end
              ccc_pkg::PTR_1: d.hour = wdata_in;
              ccc_pkg::PTR_2: d.day  = wdata_in;
              ccc_pkg::PTR_3: d.year = wdata_in;
            endcase
        ccc_pkg::REG_AWH:
          unique case (q.aptr)
            ccc_pkg::PTR_0: d.a_min  = wdata_in;
            ccc_pkg::PTR_1: d.a_wday = wdata_in[2:0];
            ccc_pkg::PTR_2: d.a_mon  = wdata_in;
            ccc_pkg::PTR_3: d.a_mon  = d.a_mon;
          endcase
        ccc_pkg::REG_AWL:
          unique case (q.aptr)
            ccc_pkg::PTR_0: d.a_sec  = wdata_in;
            ccc_pkg::PTR_1: d.a_hour = wdata_in;
            ccc_pkg::PTR_2: d.a_day  = wdata_in;
            ccc_pkg::PTR_3: d.a_day  = d.a_day;
          endcase
        default: d.rd = d.rd;
      endcase
    end

    // pointers step down on every high window access, even a locked write
    if ((wr_in || rd_in) && addr_in == ccc_pkg::REG_TWH && q.tptr != ccc_pkg::PTR_0)
      d.tptr = q.tptr - 2'h1;
    if ((wr_in || rd_in) && addr_in == ccc_pkg::REG_AWH && q.aptr != ccc_pkg::PTR_0)
      d.aptr = q.aptr - 2'h1;

    // clock pin; selects are registered so the pin lags one cycle
    unique case (q.sel)
      ccc_pkg::SEL_ALARM:   d.pin = q.alm_pulse;
      ccc_pkg::SEL_SECONDS: d.pin = q.pre[ccc_pkg::PRE_W-1];
      ccc_pkg::SEL_SOURCE:  d.pin = q.src_s[1];
      default:              d.pin = 1'b0;
    endcase
    if (!q.oe)
      d.pin = 1'b0;
    d.pin_oe = q.oe;

    // system reset spares the configuration register and the running clock
    if (srst_in)
    begin
      d.cal       = 8'h00;
      d.sel       = ccc_pkg::SEL_ALARM;
      d.alm_en    = 1'b0;
      d.chime     = 1'b0;
      d.mask      = ccc_pkg::MASK_HALF;
      d.aptr      = ccc_pkg::PTR_0;
      d.rpt       = 8'h00;
      d.alm_evt   = 1'b0;
      d.alm_pulse = 1'b0;
      d.rd        = 8'h00;
    end
    if (por_in)
    begin
      d        = '0;
      d.day    = ccc_pkg::BCD_01;
      d.mon    = ccc_pkg::BCD_01;
      d.a_day  = ccc_pkg::BCD_01;
      d.a_mon  = ccc_pkg::BCD_01;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    q <= d;
  end

  assign rdata_out       = q.rd;
  assign clk_pin_out     = q.pin;
  assign clk_pin_oe_out  = q.pin_oe;
  assign alarm_event_out = q.alm_evt;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (por_in || srst_in);

  sequence s_cfg_wr_locked;
    wr_in && addr_in == ccc_pkg::REG_CFG && !q.unlock;
  endsequence
  sequence s_twh_access;
    (wr_in || rd_in) && addr_in == ccc_pkg::REG_TWH;
  endsequence
  sequence s_awh_access;
    (wr_in || rd_in) && addr_in == ccc_pkg::REG_AWH;
  endsequence
  sequence s_evt_idle_bus;
    evt && !wr_in;
  endsequence

  property p_en_locked;
    s_cfg_wr_locked |=> q.en == $past(q.en);
  endproperty
  a_en_locked: assert property (p_en_locked) else $error("enable changed while locked");

  property p_sec_write;
    wr_in && addr_in == ccc_pkg::REG_TWL && q.unlock && q.tptr == ccc_pkg::PTR_0
      |=> q.sec == $past(wdata_in) && q.pre == 15'h0000;
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("seconds write not applied");

  property p_sec_blocked;
    wr_in && addr_in == ccc_pkg::REG_TWL && !q.unlock && !src_tick |=> $stable(q.sec);
  endproperty
  a_sec_blocked: assert property (p_sec_blocked) else $error("locked seconds write");

  property p_tptr_dec;
    s_twh_access and (q.tptr != ccc_pkg::PTR_0) |=> q.tptr == $past(q.tptr) - 2'h1;
  endproperty
  a_tptr_dec: assert property (p_tptr_dec) else $error("time pointer not stepped");

  property p_aptr_hold;
    s_awh_access and (q.aptr == ccc_pkg::PTR_0) and !wr_in |=> q.aptr == ccc_pkg::PTR_0;
  endproperty
  a_aptr_hold: assert property (p_aptr_hold) else $error("alarm pointer passed zero");

  property p_pin_off;
    !q.oe [*2] |=> !clk_pin_out && !clk_pin_oe_out;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

  property p_stopped;
    !q.en && !(wr_in && addr_in == ccc_pkg::REG_TWL) |=> $stable(q.pre);
  endproperty
  a_stopped: assert property (p_stopped) else $error("time base ran while off");

  property p_rpt_dec;
    s_evt_idle_bus and (q.rpt != 8'h00) |=> q.rpt == $past(q.rpt) - 8'h01 && q.alm_en;
  endproperty
  a_rpt_dec: assert property (p_rpt_dec) else $error("repeat count not decremented");

  property p_one_shot;
    s_evt_idle_bus and (q.rpt == 8'h00) and !q.chime |=> q.rpt == 8'h00 && !q.alm_en;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("alarm not auto-cleared");

  property p_chime_wrap;
    s_evt_idle_bus and (q.rpt == 8'h00) and q.chime |=> q.rpt == 8'hFF && alarm_event_out;
  endproperty
  a_chime_wrap: assert property (p_chime_wrap) else $error("chime wrap missing");

  property p_ro_zero;
    rd_in && addr_in == ccc_pkg::REG_CFG |=> !rdata_out[6] && rdata_out[4] == $past(sync_st);
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("config status readback wrong");

  property p_no_evt_off;
    !q.alm_en |=> !alarm_event_out;
  endproperty
  a_no_evt_off: assert property (p_no_evt_off) else $error("alarm while disabled");
endmodule : ccc_top
`default_nettype wire

// ### common/ccc_pkg.sv
package ccc_pkg;
  // ==========================================================================
  // register bus
  // ==========================================================================
  localparam int          ADDR_W = 4;
  localparam int          DATA_W = 8;
  localparam logic [3:0]  REG_CFG  = 4'h0;
  localparam logic [3:0]  REG_CAL  = 4'h1;
  localparam logic [3:0]  REG_PAD  = 4'h2;
  localparam logic [3:0]  REG_ACFG = 4'h3;
  localparam logic [3:0]  REG_ALARM_REPEAT_VALUE = 4'h4;
  localparam logic [3:0]  REG_TWH  = 4'h5;
  localparam logic [3:0]  REG_TWL  = 4'h6;
  localparam logic [3:0]  REG_AWH  = 4'h7;
  localparam logic [3:0]  REG_AWL  = 4'h8;
  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int CFG_EN_BIT     = 7;
  localparam int CFG_UNLOCK_BIT = 5;
  localparam int CFG_SYNC_BIT   = 4;
  localparam int CFG_HALF_BIT   = 3;
  localparam int CFG_OE_BIT     = 2;
  localparam int PAD_SEL_LSB    = 1;
  localparam int ACFG_EN_BIT    = 7;
  localparam int ACFG_CHIME_BIT = 6;
  localparam int ACFG_MASK_LSB  = 2;
  // ==========================================================================
  // pointer, select and mask codes
  // ==========================================================================
  localparam logic [1:0] PTR_0 = 2'h0;
  localparam logic [1:0] PTR_1 = 2'h1;
  localparam logic [1:0] PTR_2 = 2'h2;
  localparam logic [1:0] PTR_3 = 2'h3;
  localparam logic [1:0] SEL_ALARM   = 2'h0;
  localparam logic [1:0] SEL_SECONDS = 2'h1;
  localparam logic [1:0] SEL_SOURCE  = 2'h2;
  localparam logic [3:0] MASK_HALF   = 4'h0;
  localparam logic [3:0] MASK_SEC    = 4'h1;
  localparam logic [3:0] MASK_TENSEC = 4'h2;
  localparam logic [3:0] MASK_MIN    = 4'h3;
  localparam logic [3:0] MASK_TENMIN = 4'h4;
  localparam logic [3:0] MASK_HOUR   = 4'h5;
  localparam logic [3:0] MASK_DAY    = 4'h6;
  localparam logic [3:0] MASK_WEEK   = 4'h7;
  localparam logic [3:0] MASK_MONTH  = 4'h8;
  localparam logic [3:0] MASK_YEAR   = 4'h9;
  // ==========================================================================
  // bcd limits and reset values
  // ==========================================================================
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_02 = 8'h02;
  localparam logic [7:0] BCD_04 = 8'h04;
  localparam logic [7:0] BCD_06 = 8'h06;
  localparam logic [7:0] BCD_09 = 8'h09;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic [7:0] RPT_MAX   = 8'hFF;
  // ==========================================================================
  // time base, counted in source pulses
  // ==========================================================================
  localparam int          PRE_W      = 15;
  localparam logic [14:0] SYNC_START = 15'h7FE0;
endpackage : ccc_pkg

// ### rtl/ccc_alarm_match.sv
`timescale 1ns/1ps
`default_nettype none
module ccc_alarm_match
(
  input  wire logic [7:0] sec_in,
  input  wire logic [7:0] min_in,
  input  wire logic [7:0] hour_in,
  input  wire logic [7:0] day_in,
  input  wire logic [7:0] mon_in,
  input  wire logic [2:0] wday_in,
  input  wire logic [7:0] a_sec_in,
  input  wire logic [7:0] a_min_in,
  input  wire logic [7:0] a_hour_in,
  input  wire logic [7:0] a_day_in,
  input  wire logic [7:0] a_mon_in,
  input  wire logic [2:0] a_wday_in,
  input  wire logic [3:0] mask_in,
  input  wire logic       leap_in,
  output logic            match_out
);
  logic eq_sec1;
  logic eq_sec;
  logic eq_min1;
  logic eq_min;
  logic eq_hour;
  logic eq_day;
  logic eq_mon;
  logic feb29;

  assign eq_sec1 = (sec_in[3:0] == a_sec_in[3:0]);
  assign eq_sec  = (sec_in == a_sec_in);
  assign eq_min1 = (min_in[3:0] == a_min_in[3:0]);
  assign eq_min  = (min_in == a_min_in);
  assign eq_hour = (hour_in == a_hour_in);
  assign eq_day  = (day_in == a_day_in);
  assign eq_mon  = (mon_in == a_mon_in);
  assign feb29   = (a_mon_in == ccc_pkg::BCD_02) && (a_day_in == ccc_pkg::BCD_29);

  always_comb
  begin
    unique case (mask_in)
      ccc_pkg::MASK_HALF:   match_out = 1'b1;
      ccc_pkg::MASK_SEC:    match_out = 1'b1;
      ccc_pkg::MASK_TENSEC: match_out = eq_sec1;
      ccc_pkg::MASK_MIN:    match_out = eq_sec;
      ccc_pkg::MASK_TENMIN: match_out = eq_sec && eq_min1;
      ccc_pkg::MASK_HOUR:   match_out = eq_sec && eq_min;
      ccc_pkg::MASK_DAY:    match_out = eq_sec && eq_min && eq_hour;
      ccc_pkg::MASK_WEEK:   match_out = eq_sec && eq_min && eq_hour && (wday_in == a_wday_in);
      ccc_pkg::MASK_MONTH:  match_out = eq_sec && eq_min && eq_hour && eq_day;
      // february 29 only ever matches in a leap year
      ccc_pkg::MASK_YEAR:   match_out = eq_sec && eq_min && eq_hour && eq_day && eq_mon
                                        && (!feb29 || leap_in);
      // reserved codes never fire
      default:              match_out = 1'b0;
    endcase
  end
endmodule : ccc_alarm_match
`default_nettype wire

// ### testbench/calendar_clock_control_alarm_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module calendar_clock_control_alarm_config_tb;
  logic       ref_clk_in = 1'b0;
  logic       srst_in    = 1'b1;
  logic       por_in     = 1'b1;
  logic       src_clk_in = 1'b0;
  logic [3:0] addr_in    = 4'h0;
  logic [7:0] wdata_in   = 8'h00;
  logic       wr_in      = 1'b0;
  logic       rd_in      = 1'b0;
  logic [7:0] rdata_out;
  logic       clk_pin_out;
  logic       clk_pin_oe_out;
  logic       alarm_event_out;
  logic       pin_prev;
  int         errors     = 0;
  int         n_tests    = 0;
  int         cycles     = 0;
  ccc_top uut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .por_in(por_in),
    .src_clk_in(src_clk_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .clk_pin_out(clk_pin_out),
    .clk_pin_oe_out(clk_pin_oe_out), .alarm_event_out(alarm_event_out));
  // ==========================================================================
  // clocks
  // ==========================================================================
  always #20 ref_clk_in = ~ref_clk_in;
  // source sped up to one pulse per 2 cycles so a whole second fits the run
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    src_clk_in <= ~src_clk_in;
    if (cycles == 90000)
    begin
      errors++;
      test_done();
    end
  end
  // ==========================================================================
  // bus tasks
  // ==========================================================================
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1;
    chk(rdata_out & m, exp);
  endtask : rd
  task test_done();
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ==========================================================================
  // sequence
  // ==========================================================================
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    por_in  <= 1'b0;
    for (int i = 0; i < 5; i++) rd(i[3:0], 8'hFF, 8'h00);
    rd(4'h9, 8'hFF, 8'h00);
    wr(ccc_pkg::REG_CFG, 8'h80);
    rd(ccc_pkg::REG_CFG, 8'hFF, 8'h00);
    wr(ccc_pkg::REG_CFG, 8'h78);
    rd(ccc_pkg::REG_CFG, 8'hFF, 8'h20);
    wr(ccc_pkg::REG_CFG, 8'h22);
    wr(ccc_pkg::REG_TWL, 8'h15);
    wr(ccc_pkg::REG_TWH, 8'h07);
    rd(ccc_pkg::REG_CFG, 8'hFF, 8'h21);
    wr(ccc_pkg::REG_TWL, 8'h09);
    wr(ccc_pkg::REG_TWH, 8'h03);
    wr(ccc_pkg::REG_TWH, 8'h30);
    rd(ccc_pkg::REG_CFG, 8'hFF, 8'h20);
    wr(ccc_pkg::REG_CFG, 8'h02);
    wr(ccc_pkg::REG_TWL, 8'h20);
    wr(ccc_pkg::REG_CFG, 8'h22);
    rd(ccc_pkg::REG_TWL, 8'hFF, 8'h15);
    rd(ccc_pkg::REG_TWH, 8'hFF, 8'h07);
    rd(ccc_pkg::REG_TWL, 8'hFF, 8'h09);
    rd(ccc_pkg::REG_TWH, 8'hFF, 8'h03);
    rd(ccc_pkg::REG_TWH, 8'hFF, 8'h30);
    // alarm windows: day, month, hour, weekday, then minute and second
    wr(ccc_pkg::REG_ACFG, 8'h02);
    wr(ccc_pkg::REG_AWL, 8'h12);
    wr(ccc_pkg::REG_AWH, 8'h05);
    wr(ccc_pkg::REG_AWL, 8'h08);
    wr(ccc_pkg::REG_AWH, 8'h04);
    wr(ccc_pkg::REG_AWH, 8'h45);
    wr(ccc_pkg::REG_AWL, 8'h33);
    rd(ccc_pkg::REG_ACFG, 8'hFF, 8'h00);
    wr(ccc_pkg::REG_ACFG, 8'h02);
    rd(ccc_pkg::REG_AWL, 8'hFF, 8'h12);
    rd(ccc_pkg::REG_AWH, 8'hFF, 8'h05);
    rd(ccc_pkg::REG_AWL, 8'hFF, 8'h08);
    rd(ccc_pkg::REG_AWH, 8'hFF, 8'h04);
    rd(ccc_pkg::REG_AWH, 8'hFF, 8'h45);
    rd(ccc_pkg::REG_AWL, 8'hFF, 8'h33);
    wr(ccc_pkg::REG_PAD, 8'hFD);
    rd(ccc_pkg::REG_PAD, 8'hFF, 8'h04);
    wr(ccc_pkg::REG_CAL, 8'h80);
    rd(ccc_pkg::REG_CAL, 8'hFF, 8'h80);
    @(posedge ref_clk_in) srst_in <= 1'b1;
    @(posedge ref_clk_in) srst_in <= 1'b0;
    rd(ccc_pkg::REG_CAL, 8'hFF, 8'h00);
    rd(ccc_pkg::REG_CFG, 8'hFF, 8'h20);
    rd(ccc_pkg::REG_PAD, 8'hFF, 8'h00);
    rd(ccc_pkg::REG_AWL, 8'hFF, 8'h33);
    chk({7'h00, clk_pin_out}, 8'h00);
    wr(ccc_pkg::REG_CFG, 8'hA4);
    wr(ccc_pkg::REG_TWL, 8'h00);
    rd(ccc_pkg::REG_CFG, 8'hFF, 8'hA4);
    chk({7'h00, clk_pin_oe_out}, 8'h01);
    rd(ccc_pkg::REG_TWL, 8'hFF, 8'h00);
    rd(ccc_pkg::REG_TWL, 8'hFF, 8'h00);
    wr(ccc_pkg::REG_ALARM_REPEAT_VALUE, 8'h00);
    wr(ccc_pkg::REG_ACFG, 8'h80);
    // first half-second event, no repeats left and chime off
    while (alarm_event_out !== 1'b1 && cycles < 85000)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk({7'h00, clk_pin_out}, 8'h01);
    rd(ccc_pkg::REG_ACFG, 8'hFF, 8'h00);
    rd(ccc_pkg::REG_ALARM_REPEAT_VALUE, 8'hFF, 8'h00);
    rd(ccc_pkg::REG_CFG, 8'h08, 8'h08);
    // seconds clock sits in its high half, raw source toggles every cycle
    wr(ccc_pkg::REG_PAD, 8'h02);
    @(posedge ref_clk_in);
    #1;
    chk({7'h00, clk_pin_out}, 8'h01);
    wr(ccc_pkg::REG_PAD, 8'h04);
    @(posedge ref_clk_in);
    #1;
    pin_prev = clk_pin_out;
    @(posedge ref_clk_in);
    #1;
    chk({7'h00, pin_prev ^ clk_pin_out}, 8'h01);
    wr(ccc_pkg::REG_PAD, 8'h00);
    // per-second alarm with chime on and no repeats left
    wr(ccc_pkg::REG_ACFG, 8'hC4);
    while (alarm_event_out !== 1'b1 && cycles < 85000)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk({7'h00, clk_pin_out}, 8'h00);
    rd(ccc_pkg::REG_ALARM_REPEAT_VALUE, 8'hFF, 8'hFF);
    rd(ccc_pkg::REG_ACFG, 8'hFF, 8'hC4);
    rd(ccc_pkg::REG_CFG, 8'h08, 8'h00);
    rd(ccc_pkg::REG_TWL, 8'hFF, 8'h01);
    test_done();
  end
endmodule : calendar_clock_control_alarm_config_tb
`default_nettype wire
